// ### pcg_consts.svh
// Purpose: offsets, field positions, reset values, uart pin numbers and the input-only slot mask of the port crossbar
// Assumes: 8-bit special function register space, two 8-bit ports behind the crossbar
// Notes: definitions only
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// register offsets
`define PCG_ADDR_PORT0_DATA 8'h80
`define PCG_ADDR_PORT1_DATA 8'h90
`define PCG_ADDR_PORT0_OUTPUT_MODE 8'ha4
`define PCG_ADDR_PORT0_SKIP 8'hd4
`define PCG_ADDR_CROSSBAR_ROUTE_A 8'he1
`define PCG_ADDR_CROSSBAR_ROUTE_B 8'he2
`define PCG_ADDR_PORT0_INPUT_MODE 8'hf1
`define PCG_ADDR_PORT1_INPUT_MODE 8'hf2

// reset values
`define PCG_RST_PORT_DATA 8'hff
`define PCG_RST_OUTPUT_MODE 8'h00
`define PCG_RST_SKIP 8'h00
`define PCG_RST_CROSSBAR 8'h00
`define PCG_RST_INPUT_MODE 8'hff
`define PCG_UNMAPPED_READ 8'h00

// port 1 mode and skip are fixed here; port 1 acts open-drain and never skipped
`define PCG_PORT1_OUTPUT_MODE 8'h00
`define PCG_PORT1_SKIP 8'h00

// crossbar route a fields
`define PCG_BIT_CMP_B_ASYNC_ROUTE_EN 7
`define PCG_BIT_CMP_B_ROUTE_EN 6
`define PCG_BIT_CMP_A_ASYNC_ROUTE_EN 5
`define PCG_BIT_CMP_A_ROUTE_EN 4
`define PCG_BIT_CLOCK_OUT_ROUTE_EN 3
`define PCG_BIT_TWO_WIRE_ROUTE_EN 2
`define PCG_BIT_SPI_ROUTE_EN 1
`define PCG_BIT_UART_ROUTE_EN 0

// crossbar route b fields
`define PCG_BIT_PULLUP_DISABLE 7
`define PCG_BIT_CROSSBAR_ENABLE 6
`define PCG_BIT_TIMER_B_INPUT_ROUTE_EN 5
`define PCG_BIT_TIMER_A_INPUT_ROUTE_EN 4
`define PCG_BIT_EXT_COUNT_ROUTE_EN 3
`define PCG_COUNT_MSB 2
`define PCG_COUNT_LSB 0

// fixed pins of the uart
`define PCG_UART_TX_PIN 4'd4
`define PCG_UART_RX_PIN 4'd5

// slots that only ever receive and never drive a pin
`define PCG_INPUT_ONLY_MASK 21'h1c0002

`endif

// ### pcg_pkg.sv
// Purpose: types shared by the port crossbar and its users
// Assumes: slot order equals crossbar priority, uart slots first
// Notes: slot numbers index every vector of pcg_periph_t
package pcg_pkg;

    localparam int PCG_NFUNC = 21;
    localparam int PCG_NPIN = 16;

    // peripheral slots in priority order
    typedef enum logic [4:0] {
        SLOT_UART_TX, SLOT_UART_RX, SLOT_SPI_SCK, SLOT_SPI_MISO, SLOT_SPI_MOSI,
        SLOT_SPI_NSS, SLOT_TW_DATA, SLOT_TW_CLOCK, SLOT_CMP_A, SLOT_CMP_A_ASYNC,
        SLOT_CMP_B, SLOT_CMP_B_ASYNC, SLOT_SYS_CLOCK, SLOT_CNT_CH0, SLOT_CNT_CH1,
        SLOT_CNT_CH2, SLOT_CNT_CH3, SLOT_CNT_CH4, SLOT_EXT_COUNT, SLOT_TIMER_A,
        SLOT_TIMER_B
    } pcg_slot_t;

    // one special function register request
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic bitOp;
        logic [2:0] bitSel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcg_sfr_req_t;

    // peripheral side drive of each slot
    typedef struct packed {
        logic [PCG_NFUNC-1:0] value;
        logic [PCG_NFUNC-1:0] drive;
    } pcg_periph_t;

endpackage : pcg_pkg

// ### pcg_port_crossbar.sv
// Purpose: port 0/1 registers, priority crossbar decoder and pad control
// Assumes: one system clock, cpu registers reached as special function registers
// Notes: pad drive is combinational from registers and peripheral outputs
//   pad inputs are sampled, never read raw
//   port 1 has no mode or skip register: open-drain, never skipped
//   pins reach reads two edges late through the synchroniser
//   reads in the first two cycles after reset see the cleared flops
//   uart keeps pins four and five, skip bits or not
//   counter codes above five act as five
//   slots with no free pin stay unrouted and read one
//
// Contract
// - route b comparator async/sync outputs on enables
// - route a comparator async/sync outputs on enables
// - clock-out enable routes system clock to pin
// - two-wire enable routes data and clock
// - spi enable routes spi signals to pins
// - uart fixed on pins four and five
// - pull-up disable bit kills all weak pull-ups
// - crossbar enable makes assignments take effect
// - timer input enables route timer inputs
// - external count enable routes count input
// - channel count field routes channels zero upward
// - port data byte/bit writable, latched drive
// - ordinary port read returns sampled pins
// - read-modify-write reads the output latch
// - latch zero drives low, one per mode
// - analog pin reads as one
// - input-mode zero is analog, resets ones
// - output-mode one push-pull, resets zeros
// - two-wire pins always open-drain
// - skip bit passes pin over, resets zeros
// - lowest free unskipped pin per peripheral
// - crossbar off keeps all drivers off
// - no pull-up while driving low
`timescale 1ns/10ps
`include "pcg_consts.svh"

module pcg_port_crossbar
    import pcg_pkg::*;
#(
    parameter int NFUNC = PCG_NFUNC,
    parameter int NPIN = PCG_NPIN
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,

    // special function register access
    input wire pcg_sfr_req_t sfrReq,
    input wire logic spiNssPinned,
    output logic [7:0] sfrRdata,
    output logic sfrRdValid,

    // peripheral side
    input wire pcg_periph_t periph,
    output logic [NFUNC-1:0] periphIn,
    output logic [NFUNC-1:0] periphRouted,

    // pads
    input wire logic [NPIN-1:0] padIn,
    output logic [NPIN-1:0] padOut,
    output logic [NPIN-1:0] padOe,
    output logic [NPIN-1:0] padPullup
);

    // registers, all reset on one edge so the first access sees a
    // consistent set; port 1 latch drives pins 15:8
    logic [7:0] port0Data;
    logic [7:0] port1Data;
    logic [7:0] port0OutputMode;
    logic [7:0] port0Skip;
    logic [7:0] crossbarRouteA;
    logic [7:0] crossbarRouteB;
    logic [7:0] port0InputMode;
    logic [7:0] port1InputMode;

    // pad synchroniser, first stage read only by the second
    logic [NPIN-1:0] padMeta;
    logic [NPIN-1:0] padSync;

    // merged byte-wide write value for a bit or byte access
    // a bit write leaves the other latch bits and their pins alone
    function automatic logic [7:0] pcg_merge(input logic [7:0] old, input pcg_sfr_req_t r);
        logic [7:0] res;
        res = old;
        if (r.bitOp) begin
            res[r.bitSel] = r.wdata[0];
        end else begin
            // byte write replaces the whole latch
            res = r.wdata;
        end
        return res;
    endfunction : pcg_merge

    // address decode, at most one hit per address; a miss reads the
    // unmapped value and its writes are lost
    wire hitPort0Data = sfrReq.addr == `PCG_ADDR_PORT0_DATA;
    wire hitPort1Data = sfrReq.addr == `PCG_ADDR_PORT1_DATA;
    wire hitPort0OutputMode = sfrReq.addr == `PCG_ADDR_PORT0_OUTPUT_MODE;
    wire hitPort0Skip = sfrReq.addr == `PCG_ADDR_PORT0_SKIP;
    wire hitCrossbarRouteA = sfrReq.addr == `PCG_ADDR_CROSSBAR_ROUTE_A;
    wire hitCrossbarRouteB = sfrReq.addr == `PCG_ADDR_CROSSBAR_ROUTE_B;
    wire hitPort0InputMode = sfrReq.addr == `PCG_ADDR_PORT0_INPUT_MODE;
    wire hitPort1InputMode = sfrReq.addr == `PCG_ADDR_PORT1_INPUT_MODE;

    // only the two port registers are bit addressable; other bit writes are dropped
    // a bit write to a mode register has no clear meaning, so it is lost
    wire byteWr = sfrReq.wr & ~sfrReq.bitOp;
    wire portWr = sfrReq.wr;
    wire [7:0] next_port0Data = pcg_merge(port0Data, sfrReq);
    wire [7:0] next_port1Data = pcg_merge(port1Data, sfrReq);

    // register writes; a read in the same cycle still sees the old
    // value, since these change only at the edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            // documented reset values
            port0Data <= `PCG_RST_PORT_DATA;
            port1Data <= `PCG_RST_PORT_DATA;
            port0OutputMode <= `PCG_RST_OUTPUT_MODE;
            port0Skip <= `PCG_RST_SKIP;
            crossbarRouteA <= `PCG_RST_CROSSBAR;
            crossbarRouteB <= `PCG_RST_CROSSBAR;
            port0InputMode <= `PCG_RST_INPUT_MODE;
            port1InputMode <= `PCG_RST_INPUT_MODE;
        end else begin
            // port latches take bit or byte writes
            if (portWr && hitPort0Data) port0Data <= next_port0Data;
            if (portWr && hitPort1Data) port1Data <= next_port1Data;

            // the rest take byte writes only
            if (byteWr && hitPort0OutputMode) port0OutputMode <= sfrReq.wdata;
            if (byteWr && hitPort0Skip) port0Skip <= sfrReq.wdata;
            if (byteWr && hitCrossbarRouteA) crossbarRouteA <= sfrReq.wdata;
            if (byteWr && hitCrossbarRouteB) crossbarRouteB <= sfrReq.wdata;
            if (byteWr && hitPort0InputMode) port0InputMode <= sfrReq.wdata;
            if (byteWr && hitPort1InputMode) port1InputMode <= sfrReq.wdata;
        end
    end

    // two-flop sampling of the pads, they come from outside this clock
    // only the second stage is read; reset clears both, so digital pins
    // read zero for the first two cycles after reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            padMeta <= '0;
            padSync <= '0;
        end else begin
            padMeta <= padIn;
            padSync <= padMeta;
        end
    end

    // per-pin views of the mode registers
    // port 1 mode and skip are constants: open-drain, never skipped
    wire [NPIN-1:0] latchAll = {port1Data, port0Data};
    wire [NPIN-1:0] digitalPin = {port1InputMode, port0InputMode};
    wire [NPIN-1:0] pushPullMode = {`PCG_PORT1_OUTPUT_MODE, port0OutputMode};
    wire [NPIN-1:0] skipPin = {`PCG_PORT1_SKIP, port0Skip};

    // analog pins read one, digital pins read the sampled level
    // a pin owned by a peripheral still reads back, so software can
    // watch a routed signal without disturbing it
    wire [NPIN-1:0] pinRead = padSync | ~digitalPin;

    // rmw reads the latch so pins held low elsewhere are not written back
    // a wired-and line held low by another chip would otherwise turn
    // a released bit into a driven zero
    wire [7:0] port0Read = sfrReq.rmw ? port0Data : pinRead[7:0];
    wire [7:0] port1Read = sfrReq.rmw ? port1Data : pinRead[15:8];

    // read multiplexer
    // a miss returns a fixed value, never stale data
    wire [7:0] readMux =
        hitPort0Data ? port0Read :
        hitPort1Data ? port1Read :
        hitPort0OutputMode ? port0OutputMode :
        hitPort0Skip ? port0Skip :
        hitCrossbarRouteA ? crossbarRouteA :
        hitCrossbarRouteB ? crossbarRouteB :
        hitPort0InputMode ? port0InputMode :
        hitPort1InputMode ? port1InputMode :
        `PCG_UNMAPPED_READ;

    // read data held until the next read
    // valid pulses for one cycle; data waits for a slow reader
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sfrRdata <= 8'h00;
            sfrRdValid <= 1'b0;
        end else begin
            sfrRdValid <= sfrReq.rd;
            // data moves only on a read
            if (sfrReq.rd) sfrRdata <= readMux;
        end
    end

    // crossbar control fields
    // other enables are read in the request table beside their slot
    wire crossbarEnable = crossbarRouteB[`PCG_BIT_CROSSBAR_ENABLE];
    wire pullupDisable = crossbarRouteB[`PCG_BIT_PULLUP_DISABLE];
    wire [2:0] counterChannelCount = crossbarRouteB[`PCG_COUNT_MSB:`PCG_COUNT_LSB];
    wire uartRouteEn = crossbarRouteA[`PCG_BIT_UART_ROUTE_EN];
    wire spiRouteEn = crossbarRouteA[`PCG_BIT_SPI_ROUTE_EN];
    wire twoWireRouteEn = crossbarRouteA[`PCG_BIT_TWO_WIRE_ROUTE_EN];

    // slot requests before the global enable, one bit per slot
    // nss asks for a pin only in four-wire mode; in three-wire mode
    // the pin stays free for the next slot in priority
    logic [NFUNC-1:0] slotReq;
    always_comb begin
        slotReq = '0;

        // enables of the first route register
        slotReq[SLOT_UART_TX] = uartRouteEn;
        slotReq[SLOT_UART_RX] = uartRouteEn;
        slotReq[SLOT_SPI_SCK] = spiRouteEn;
        slotReq[SLOT_SPI_MISO] = spiRouteEn;
        slotReq[SLOT_SPI_MOSI] = spiRouteEn;
        slotReq[SLOT_SPI_NSS] = spiRouteEn & spiNssPinned;
        slotReq[SLOT_TW_DATA] = twoWireRouteEn;
        slotReq[SLOT_TW_CLOCK] = twoWireRouteEn;
        slotReq[SLOT_CMP_A] = crossbarRouteA[`PCG_BIT_CMP_A_ROUTE_EN];
        slotReq[SLOT_CMP_A_ASYNC] = crossbarRouteA[`PCG_BIT_CMP_A_ASYNC_ROUTE_EN];
        slotReq[SLOT_CMP_B] = crossbarRouteA[`PCG_BIT_CMP_B_ROUTE_EN];
        slotReq[SLOT_CMP_B_ASYNC] = crossbarRouteA[`PCG_BIT_CMP_B_ASYNC_ROUTE_EN];
        slotReq[SLOT_SYS_CLOCK] = crossbarRouteA[`PCG_BIT_CLOCK_OUT_ROUTE_EN];

        // codes above five saturate at all five channels
        // each code up to five asks for one channel more than the code below it
        for (int c = 0; c < 5; c++) begin
            slotReq[int'(SLOT_CNT_CH0) + c] = counterChannelCount > 3'(c);
        end

        // count and timer enables of the second route register
        slotReq[SLOT_EXT_COUNT] = crossbarRouteB[`PCG_BIT_EXT_COUNT_ROUTE_EN];
        slotReq[SLOT_TIMER_A] = crossbarRouteB[`PCG_BIT_TIMER_A_INPUT_ROUTE_EN];
        slotReq[SLOT_TIMER_B] = crossbarRouteB[`PCG_BIT_TIMER_B_INPUT_ROUTE_EN];
    end

    // nothing is routed while the crossbar is off
    // pins keep their port role meanwhile, as inputs with drivers off
    wire [NFUNC-1:0] slotEn = crossbarEnable ? slotReq : '0;

    // priority decoder: slot order is priority, each takes the lowest free pin
    // taken starts as the skip bits, so a skipped pin looks assigned;
    // every slot after the uart scans every pin, a long but static chain that only
    // moves on a register write or on spiNssPinned; found stops a second claim
    logic [NPIN-1:0] taken;
    logic [NFUNC-1:0] slotHit;
    logic [3:0] slotPin [NFUNC];
    logic found;
    always_comb begin
        taken = skipPin;
        slotHit = '0;
        found = 1'b0;
        // pin numbers are only read where the slot hit
        for (int f = 0; f < NFUNC; f++) begin
            slotPin[f] = 4'd0;
        end

        // uart ignores skip and priority, always on its own two pins
        // its pins are marked taken so later slots pass them over
        if (slotEn[SLOT_UART_TX]) begin
            slotHit[SLOT_UART_TX] = 1'b1;
            slotPin[SLOT_UART_TX] = `PCG_UART_TX_PIN;
            slotHit[SLOT_UART_RX] = 1'b1;
            slotPin[SLOT_UART_RX] = `PCG_UART_RX_PIN;
            taken[`PCG_UART_TX_PIN] = 1'b1;
            taken[`PCG_UART_RX_PIN] = 1'b1;
        end

        // remaining slots in priority order
        for (int f = 2; f < NFUNC; f++) begin
            found = 1'b0;
            for (int p = 0; p < NPIN; p++) begin
                if (slotEn[f] && !found && !taken[p]) begin
                    slotHit[f] = 1'b1;
                    slotPin[f] = 4'(p);
                    taken[p] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    end

    // per-pin owner lookup; slots beyond the last free pin stay unrouted
    // a pin is marked taken once assigned, so it has at most one owner
    logic [NPIN-1:0] pinOwned;
    logic [4:0] pinSlot [NPIN];
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            // default: no owner
            pinOwned[p] = 1'b0;
            pinSlot[p] = 5'd0;
            for (int f = 0; f < NFUNC; f++) begin
                if (slotHit[f] && slotPin[f] == 4'(p)) begin
                    pinOwned[p] = 1'b1;
                    pinSlot[p] = 5'(f);
                end
            end
        end
    end

    // value and drive wanted by each pin before the mode registers apply
    // an unowned pin carries its port latch and asks to drive;
    // two-wire pins are forced open-drain whatever the mode says
    logic [NPIN-1:0] wantValue;
    logic [NPIN-1:0] wantDrive;
    logic [NPIN-1:0] forceOpenDrain;
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            if (pinOwned[p]) begin
                // drive as the peripheral asks; receive-only slots masked below
                wantValue[p] = periph.value[pinSlot[p]];
                wantDrive[p] = periph.drive[pinSlot[p]];
                forceOpenDrain[p] = pinSlot[p] == 5'(SLOT_TW_DATA) ||
                    pinSlot[p] == 5'(SLOT_TW_CLOCK);
            end else begin
                // general-purpose pin: the latch decides
                wantValue[p] = latchAll[p];
                wantDrive[p] = 1'b1;
                forceOpenDrain[p] = 1'b0;
            end
        end
    end

    // input-only slots masked out of the drive request
    // uart receive, count and timer inputs leave the pin undriven so
    // the board can drive it
    localparam logic [NFUNC-1:0] INPUT_ONLY = `PCG_INPUT_ONLY_MASK;
    logic [NPIN-1:0] slotCanDrive;
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            // owned receive-only slot: no drive
            slotCanDrive[p] = ~pinOwned[p] | ~INPUT_ONLY[pinSlot[p]];
        end
    end

    // effective output type: push-pull only for digital, non two-wire pins
    // analog pins and a disabled crossbar turn the driver off whatever
    // the latch or the peripheral asks for
    wire [NPIN-1:0] pushPull = pushPullMode & digitalPin & ~forceOpenDrain;
    wire [NPIN-1:0] active = wantDrive & slotCanDrive & digitalPin & {NPIN{crossbarEnable}};

    // zero pulls low, one drives high only in push-pull
    // an open-drain one releases the pin to the pull-up
    assign padOut = pushPull & wantValue;
    assign padOe = active & (pushPull | ~wantValue);

    // weak pull-up on digital open-drain pins unless disabled or pulling low
    // pull-ups stay on with the crossbar off so idle open-drain pins do
    // not float; dropping them while pulling low saves power
    assign padPullup = {NPIN{~pullupDisable}} & digitalPin & ~pushPull
        & ~(padOe & ~wantValue);

    // peripheral inputs see the sampled level of their pin, idle high
    // three edges behind the pin: two to sample, one to register;
    // an unrouted input reads one, the idle level of most pins
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            periphIn <= '1;
            periphRouted <= '0;
        end else begin
            // owned slots sample their pin, others idle high
            periphRouted <= slotHit;
            for (int f = 0; f < NFUNC; f++) begin
                periphIn[f] <= slotHit[f] ? pinRead[slotPin[f]] : 1'b1;
            end
        end
    end

endmodule : pcg_port_crossbar

// ### pcg_xbar_monitor.sv
// Purpose: pin and register-port checks for the port crossbar
// Assumes: shadow enables follow byte writes on the same edge as the design
// Notes: bound to every crossbar instance at the foot of this file
`timescale 1ns/10ps
module pcg_xbar_monitor
    import pcg_pkg::*;
#(
    parameter int NFUNC = PCG_NFUNC,
    parameter int NPIN = PCG_NPIN
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire pcg_sfr_req_t sfrReq,
    input wire logic sfrRdValid,
    // peripheral side
    input wire pcg_periph_t periph,
    input wire logic [NFUNC-1:0] periphIn,
    input wire logic [NFUNC-1:0] periphRouted,
    // pads
    input wire logic [NPIN-1:0] padOut,
    input wire logic [NPIN-1:0] padOe,
    input wire logic [NPIN-1:0] padPullup
);
    logic [7:0] routeA;
    logic [7:0] routeB;
    logic [7:0] inMode;
    // bit writes never reach these registers
    wire logic byteWr = sfrReq.wr && !sfrReq.bitOp;
    wire logic [7:0] next_routeA = (byteWr && sfrReq.addr == 8'he1) ? sfrReq.wdata : routeA;
    wire logic [7:0] next_routeB = (byteWr && sfrReq.addr == 8'he2) ? sfrReq.wdata : routeB;
    wire logic [7:0] next_inMode = (byteWr && sfrReq.addr == 8'hf1) ? sfrReq.wdata : inMode;
    // shadow copies of the enables
    always_ff @(posedge mclk) begin
        routeA <= resetn ? next_routeA : 8'h00;
        routeB <= resetn ? next_routeB : 8'h00;
        inMode <= resetn ? next_inMode : 8'hff;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    rd_answer_a: assert property (sfrReq.rd |=> sfrRdValid)
        else $error("read not answered");
    rd_pulse_a: assert property (!sfrReq.rd |=> !sfrRdValid)
        else $error("read valid without read");
    xbar_off_a: assert property (!routeB[6] |-> padOe == '0)
        else $error("pad driven with crossbar off");
    unrouted_off_a: assert property (!routeB[6] [*2] |-> periphRouted == '0)
        else $error("slot routed with crossbar off");
    analog_quiet_a: assert property (((padOe[7:0] | padPullup[7:0]) & ~inMode) == 8'h00)
        else $error("analog pin driven or pulled up");
    pull_off_a: assert property (routeB[7] |-> padPullup == '0)
        else $error("pull-up on while disabled");
    low_no_pull_a: assert property ((padOe & ~padOut & padPullup) == '0)
        else $error("pull-up on a pin driven low");
    uart_pin_a: assert property (routeB[6] && routeA[0] && inMode[4] && periph.drive[0]
        && !periph.value[0] |-> padOe[4] && !padOut[4])
        else $error("transmit not on pin four");
    unrouted_high_a: assert property ((periphIn | periphRouted) == '1)
        else $error("unrouted slot input not high");
    cover property (sfrReq.rd ##1 sfrRdValid);
    cover property (routeB[6] && padOe != '0);
    cover property (periphRouted[7:6] == 2'b11);
endmodule : pcg_xbar_monitor
bind pcg_port_crossbar pcg_xbar_monitor #(.NFUNC(NFUNC), .NPIN(NPIN)) u_pcg_xbar_monitor (
    .mclk(mclk), .resetn(resetn), .sfrReq(sfrReq), .sfrRdValid(sfrRdValid), .periph(periph),
    .periphIn(periphIn), .periphRouted(periphRouted), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup)
);

// ### tb_top.sv
// Purpose: directed scenarios for the port crossbar
// Assumes: inputs change at the falling edge
// Notes: released pads take the board level held in extPins
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import pcg_pkg::*;
    logic mclk;
    logic resetn;
    pcg_sfr_req_t sfrReq;
    logic spiNssPinned;
    logic [7:0] sfrRdata;
    logic sfrRdValid;
    logic lastValid;
    pcg_periph_t periph;
    logic [20:0] periphIn;
    logic [20:0] periphRouted;
    logic [15:0] padIn;
    logic [15:0] padOut;
    logic [15:0] padOe;
    logic [15:0] padPullup;
    logic [15:0] extPins;
    int n_errors;
    int total_checks;
    localparam logic [7:0] RA [9] = '{8'ha4, 8'hd4, 8'he1, 8'he2, 8'hf1, 8'hf2, 8'h80, 8'h90, 8'h33};
    localparam logic [7:0] RR [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
    localparam logic [7:0] RV [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
        8'h60, 8'h50, 8'h48};
    localparam logic [20:0] RM [11] = '{21'h800, 21'h400, 21'h200, 21'h100, 21'h1000, 21'hc0,
        21'h1c, 21'h3, 21'h100000, 21'h80000, 21'h40000};
    // driven pads win over the board level
    assign padIn = (padOe & padOut) | (~padOe & extPins);
    pcg_port_crossbar u_pcg_port_crossbar (
        .mclk(mclk), .resetn(resetn), .sfrReq(sfrReq), .spiNssPinned(spiNssPinned),
        .sfrRdata(sfrRdata), .sfrRdValid(sfrRdValid), .periph(periph), .periphIn(periphIn),
        .periphRouted(periphRouted), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullup(padPullup)
    );
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // one access over one rising edge, then a quiet cycle so no pulse is reassigned
    task automatic req(input pcg_sfr_req_t r);
        sfrReq = r;
        @(negedge mclk);
        lastValid = sfrRdValid;
        sfrReq = '0;
        @(negedge mclk);
    endtask : req
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req({4'b1000, 3'd0, a, d});
    endtask : wr
    task automatic rdc(input logic m, input logic [7:0] a, input logic [7:0] e);
        req({2'b01, m, 1'b0, 3'd0, a, 8'h00});
        `CHK({lastValid, sfrRdata}, {1'b1, e})
    endtask : rdc
    // reset values, read-back, unmapped place
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            rdc(1'b1, RA[i], RR[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(RA[i], 8'h5a);
            rdc(1'b0, RA[i], 8'h5a);
            wr(RA[i], RR[i]);
        end
        wr(8'h33, 8'h5a);
        rdc(1'b0, 8'h33, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    // latch, mode and pull-up with the crossbar off and on
    task automatic t_pads();
        wr(8'h80, 8'h00);
        `CHK(padOe, 16'h0000)
        wr(8'he2, 8'h40);
        `CHK({padOe[7:0], padOut[7:0], padPullup[7:0]}, 24'hff0000)
        `CHK(padPullup[15:8], 8'hff)
        wr(8'he2, 8'hc0);
        `CHK(padPullup, 16'h0000)
        wr(8'ha4, 8'hf0);
        wr(8'h80, 8'ha5);
        `CHK({padOe[7:0], padOut[7:4]}, 12'hfaa)
        wr(8'hf1, 8'h0f);
        `CHK(padOe[7:0], 8'h0a)
        wr(8'hf1, 8'hff);
        wr(8'ha4, 8'h00);
        wr(8'h80, 8'hff);
        $display("t_pads done");
    endtask : t_pads
    // bit writes; latch reads differ from pin reads
    task automatic t_bits();
        wr(8'he2, 8'h40);
        req({4'b1001, 3'd3, 8'h80, 8'h00});
        req({4'b1001, 3'd7, 8'h90, 8'h00});
        rdc(1'b1, 8'h80, 8'hf7);
        rdc(1'b1, 8'h90, 8'h7f);
        extPins[2] = 1'b0;
        repeat (2) @(negedge mclk);
        rdc(1'b0, 8'h80, 8'hf3);
        rdc(1'b1, 8'h80, 8'hf7);
        wr(8'hd4, 8'h04);
        wr(8'hf1, 8'hfb);
        rdc(1'b0, 8'h80, 8'hf7);
        wr(8'hd4, 8'h00);
        extPins = 16'hffff;
        wr(8'hf1, 8'hff);
        wr(8'h80, 8'hff);
        wr(8'h90, 8'hff);
        $display("t_bits done");
    endtask : t_bits
    // every enable alone, then each channel count
    task automatic t_routes();
        wr(8'he2, 8'h00);
        wr(8'he1, 8'h01);
        `CHK(periphRouted, 21'h0)
        for (int i = 0; i < 11; i++) begin
            wr(8'he1, i < 8 ? RV[i] : 8'h00);
            wr(8'he2, i < 8 ? 8'h40 : RV[i]);
            `CHK(periphRouted, RM[i])
        end
        for (int k = 0; k < 8; k++) begin
            wr(8'he2, 8'h40 | 8'(k));
            `CHK(periphRouted, 21'((1 << (k > 5 ? 5 : k)) - 1) << 13)
        end
        spiNssPinned = 1'b1;
        wr(8'he1, 8'h02);
        wr(8'he2, 8'h40);
        `CHK(periphRouted, 21'h3c)
        spiNssPinned = 1'b0;
        $display("t_routes done");
    endtask : t_routes
    // fixed transmit pins, skip moves the clock pin up
    task automatic t_uart();
        wr(8'he1, 8'h03);
        wr(8'hd4, 8'h30);
        periph = {21'h0, 21'h5};
        extPins[5] = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK({padOe[4], padOut[4], padOe[0], padOut[0]}, 4'b1010)
        `CHK(periphIn[1], 1'b0)
        wr(8'hd4, 8'h31);
        `CHK(padOe[1:0], 2'b10)
        periph = '0;
        extPins = 16'hffff;
        wr(8'hd4, 8'h00);
        $display("t_uart done");
    endtask : t_uart
    // two-wire pins stay open-drain under push-pull mode
    task automatic t_twowire();
        wr(8'ha4, 8'hff);
        wr(8'he1, 8'h04);
        periph = {21'h40, 21'h40};
        @(negedge mclk);
        `CHK({padOe[0], periphRouted[7:6]}, 3'b011)
        periph = {21'h0, 21'h40};
        @(negedge mclk);
        `CHK({padOe[0], padOut[0]}, 2'b10)
        periph = '0;
        $display("t_twowire done");
    endtask : t_twowire
    // reset in mid-run brings registers and pads back to idle
    task automatic t_reset();
        wr(8'h80, 8'h00);
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        `CHK({padOe, padPullup}, 32'h0000ffff)
        rdc(1'b1, 8'h80, 8'hff);
        rdc(1'b0, 8'he2, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    initial begin
        sfrReq = '0;
        spiNssPinned = 1'b0;
        periph = '0;
        extPins = 16'hffff;
        resetn = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        t_regs();
        t_pads();
        t_bits();
        t_routes();
        t_uart();
        t_twowire();
        t_reset();
        test_done();
    end
    // cut a hung run short
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : tb_top
